// File: core/t16wg_compare.v
// One compare channel: double-buffered compare value, match flagging and output waveform
`timescale 1ns/1ns
module t16wg_compare #(
  parameter WIDTH = 16
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_tick,
  input wire [WIDTH-1:0] i_count,
  input wire [WIDTH-1:0] i_top,
  input wire [WIDTH-1:0] i_buffer,
  input wire i_immediate,
  input wire i_reload,
  input wire i_fast,
  input wire i_dual,
  input wire i_count_up,
  input wire i_at_top,
  input wire i_toggle_ok,
  input wire [1:0] i_out_mode,
  output wire [WIDTH-1:0] o_active,
  output wire o_wave,
  output wire o_connected,
  output wire o_flag_set
);

  reg [WIDTH-1:0] active_ff;
  reg wave_ff;
  reg pend_ff;
  reg nxt_wave;
  wire eq;
  wire match;
  wire ignore_match;

  assign eq = (i_count == active_ff);
  assign match = i_tick & eq;
  // Match at TOP in fast mode gives way to the TOP action
  assign ignore_match = i_fast & i_out_mode[1] & (active_ff == i_top);
  assign o_active = active_ff;
  assign o_wave = wave_ff;
  assign o_connected = (i_out_mode != 2'h0) & ((i_out_mode != 2'h1) | i_toggle_ok);
  assign o_flag_set = i_tick & pend_ff;

  // --------------------------------------------------------------------
  // Compare value update
  // --------------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_ff <= {WIDTH{1'b0}};
    end else if (i_immediate || (i_tick && i_reload)) begin
      active_ff <= i_buffer;
    end
  end

  // --------------------------------------------------------------------
  // Match flag one tick after the equal count
  // --------------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff <= 1'b0;
    end else if (i_tick) begin
      pend_ff <= eq;
    end
  end

  // --------------------------------------------------------------------
  // Waveform action
  // --------------------------------------------------------------------
  always @* begin
    nxt_wave = wave_ff;
    if (i_fast) begin
      if (i_out_mode == 2'h1) begin
        if (match && i_toggle_ok) begin
          nxt_wave = ~wave_ff;
        end
      end else if (i_out_mode[1]) begin
        if (i_tick && i_at_top) begin
          nxt_wave = ~i_out_mode[0];
        end else if (match && !ignore_match) begin
          nxt_wave = i_out_mode[0];
        end
      end
    end else if (i_dual) begin
      if (match && (i_out_mode == 2'h1) && i_toggle_ok) begin
        nxt_wave = ~wave_ff;
      end else if (match && i_out_mode[1]) begin
        nxt_wave = i_count_up ? i_out_mode[0] : ~i_out_mode[0];
      end
    end else if (match) begin
      case (i_out_mode)
        2'h1: nxt_wave = ~wave_ff;
        2'h2: nxt_wave = 1'b0;
        2'h3: nxt_wave = 1'b1;
        default: nxt_wave = wave_ff;
      endcase
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

endmodule

// File: core/t16wg_defs.vh
// Register map, field positions, reset values and timing constants of the waveform timer
`ifndef T16WG_DEFS_VH
`define T16WG_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define T16WG_ADDR_CTRL_A 6'h00
`define T16WG_ADDR_CTRL_B 6'h04
`define T16WG_ADDR_COUNT 6'h08
`define T16WG_ADDR_CMP_A 6'h0c
`define T16WG_ADDR_CMP_B 6'h10
`define T16WG_ADDR_CAPT 6'h14
`define T16WG_ADDR_IRQ_STAT 6'h18
`define T16WG_ADDR_IRQ_CLR 6'h1c
`define T16WG_ADDR_IRQ_EN 6'h20
`define T16WG_ADDR_PIN_DIR 6'h24

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define T16WG_CA_MODE_A 7:6
`define T16WG_CA_MODE_B 5:4
`define T16WG_CA_WAVE_LO 1:0
`define T16WG_CB_WAVE_HI 4:3
`define T16WG_CB_CLK_SEL 2:0
`define T16WG_IRQ_OVF 0
`define T16WG_IRQ_MATCH_A 1
`define T16WG_IRQ_MATCH_B 2

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define T16WG_CTRL_A_RST 8'h00
`define T16WG_CTRL_A_MASK 8'hf3
`define T16WG_CTRL_B_RST 5'h00
`define T16WG_WORD_RST 16'h0000
`define T16WG_IRQ_RST 3'h0
`define T16WG_DIR_RST 2'h0

// ----------------------------------------------------------------------
// Counter limits
// ----------------------------------------------------------------------
`define T16WG_BOTTOM 16'h0000
`define T16WG_MAX 16'hffff
`define T16WG_TOP_8 16'h00ff
`define T16WG_TOP_9 16'h01ff
`define T16WG_TOP_10 16'h03ff

// ----------------------------------------------------------------------
// Prescaler selections and terminal counts
// ----------------------------------------------------------------------
`define T16WG_CLK_STOP 3'h0
`define T16WG_CLK_DIV1 3'h1
`define T16WG_CLK_DIV8 3'h2
`define T16WG_CLK_DIV64 3'h3
`define T16WG_CLK_DIV256 3'h4
`define T16WG_CLK_DIV1024 3'h5
`define T16WG_PRE_END8 10'h007
`define T16WG_PRE_END64 10'h03f
`define T16WG_PRE_END256 10'h0ff
`define T16WG_PRE_END1024 10'h3ff
`define T16WG_PRE_ZERO 10'h000

`endif

// File: core/t16wg_timer.v
// Top of the 16-bit waveform timer: APB registers, prescaler, counter, two channels, interrupt
`timescale 1ns/1ns
`include "t16wg_defs.vh"

module t16wg_timer #(
  parameter WIDTH = 16
) (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [5:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire o_chan_a_wave_pin,
  output wire o_chan_a_wave_oe,
  output wire o_chan_b_wave_pin,
  output wire o_chan_b_wave_oe,
  output wire o_irq
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] waveform_control_a_ff;
  reg [4:0] control_b_ff;
  reg [WIDTH-1:0] counter_value_ff;
  reg [WIDTH-1:0] cmp_buf_a_ff;
  reg [WIDTH-1:0] cmp_buf_b_ff;
  reg [WIDTH-1:0] capture_value_reg_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_en_ff;
  reg [1:0] pin_dir_ff;
  reg count_up_ff;
  reg [9:0] pre_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] prdata_ff;
  reg pin_a_ff;
  reg oe_a_ff;
  reg pin_b_ff;
  reg oe_b_ff;
  reg irq_ff;

  reg [31:0] nxt_prdata;
  reg nxt_pslverr;
  reg [9:0] pre_end;
  reg [WIDTH-1:0] top;
  reg [WIDTH-1:0] nxt_count;
  reg nxt_up;

  wire [3:0] waveform_mode_select;
  wire [2:0] clk_sel;
  wire timer_tick_enable;
  wire access;
  wire wr;
  wire is_normal;
  wire clear_on_match_mode;
  wire is_fast;
  wire is_pc;
  wire is_pfc;
  wire is_dual;
  wire top_from_capture;
  wire top_from_a;
  wire at_top;
  wire at_bottom;
  wire immediate;
  wire reload;
  wire ovf_set;
  wire tog_ok_a;
  wire [WIDTH-1:0] act_a;
  wire [WIDTH-1:0] act_b;
  wire wave_a;
  wire wave_b;
  wire conn_a;
  wire conn_b;
  wire flag_a;
  wire flag_b;
  wire [2:0] irq_set;
  wire [2:0] irq_clr;

  // --------------------------------------------------------------------
  // Mode decode
  // --------------------------------------------------------------------
  assign waveform_mode_select = {control_b_ff[`T16WG_CB_WAVE_HI],
                                 waveform_control_a_ff[`T16WG_CA_WAVE_LO]};
  assign clk_sel = control_b_ff[`T16WG_CB_CLK_SEL];
  // Mode 13 is left undecoded and counts up from 0 to 0x00ff, then wraps, with no overflow flag
  assign is_normal = (waveform_mode_select == 4'h0);
  assign clear_on_match_mode = (waveform_mode_select == 4'h4) ||
                               (waveform_mode_select == 4'hc);
  assign is_fast = ((waveform_mode_select[3:2] == 2'h1) && (waveform_mode_select[1:0] != 2'h0)) ||
                   (waveform_mode_select[3:1] == 3'h7);
  assign is_pc = ((waveform_mode_select[3:2] == 2'h0) && (waveform_mode_select[1:0] != 2'h0)) ||
                 (waveform_mode_select[3:1] == 3'h5);
  assign is_pfc = (waveform_mode_select[3:1] == 3'h4);
  assign is_dual = is_pc | is_pfc;
  assign top_from_capture = (waveform_mode_select == 4'h8) || (waveform_mode_select == 4'ha) ||
                            (waveform_mode_select == 4'hc) || (waveform_mode_select == 4'he);
  assign top_from_a = (waveform_mode_select == 4'h4) || (waveform_mode_select == 4'h9) ||
                      (waveform_mode_select == 4'hb) || (waveform_mode_select == 4'hf);

  always @* begin
    if (top_from_capture) begin
      top = capture_value_reg_ff;
    end else if (top_from_a) begin
      top = act_a;
    end else if (is_normal) begin
      top = `T16WG_MAX;
    end else begin
      case (waveform_mode_select[1:0])
        2'h1: top = `T16WG_TOP_8;
        2'h2: top = `T16WG_TOP_9;
        default: top = `T16WG_TOP_10;
      endcase
    end
  end

  assign at_top = (counter_value_ff == top);
  assign at_bottom = (counter_value_ff == `T16WG_BOTTOM);
  assign immediate = is_normal | clear_on_match_mode;
  assign reload = is_pfc ? at_bottom : at_top;
  assign ovf_set = timer_tick_enable & (is_dual ? (at_bottom & ~count_up_ff) :
                   is_fast ? at_top : (counter_value_ff == `T16WG_MAX));
  assign tog_ok_a = (is_fast & waveform_mode_select[3]) |
                    (is_dual & waveform_mode_select[3]) |
                    ~(is_fast | is_dual);

  // --------------------------------------------------------------------
  // Prescaler: one-cycle tick enable
  // --------------------------------------------------------------------
  always @* begin
    case (clk_sel)
      `T16WG_CLK_DIV8: pre_end = `T16WG_PRE_END8;
      `T16WG_CLK_DIV64: pre_end = `T16WG_PRE_END64;
      `T16WG_CLK_DIV256: pre_end = `T16WG_PRE_END256;
      `T16WG_CLK_DIV1024: pre_end = `T16WG_PRE_END1024;
      default: pre_end = `T16WG_PRE_ZERO;
    endcase
  end

  assign timer_tick_enable = (clk_sel != `T16WG_CLK_STOP) && (clk_sel <= `T16WG_CLK_DIV1024) &&
                             (pre_ff == pre_end);

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_ff <= `T16WG_PRE_ZERO;
    end else if (timer_tick_enable || (clk_sel == `T16WG_CLK_STOP)) begin
      pre_ff <= `T16WG_PRE_ZERO;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  // --------------------------------------------------------------------
  // APB access
  // --------------------------------------------------------------------
  assign access = i_psel & i_penable & pready_ff;
  assign wr = access & i_pwrite;

  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (i_paddr == `T16WG_ADDR_CTRL_A) begin
      nxt_prdata[7:0] = waveform_control_a_ff & `T16WG_CTRL_A_MASK;
    end else if (i_paddr == `T16WG_ADDR_CTRL_B) begin
      nxt_prdata[4:0] = control_b_ff;
    end else if (i_paddr == `T16WG_ADDR_COUNT) begin
      nxt_prdata[WIDTH-1:0] = counter_value_ff;
    end else if (i_paddr == `T16WG_ADDR_CMP_A) begin
      nxt_prdata[WIDTH-1:0] = cmp_buf_a_ff;
    end else if (i_paddr == `T16WG_ADDR_CMP_B) begin
      nxt_prdata[WIDTH-1:0] = cmp_buf_b_ff;
    end else if (i_paddr == `T16WG_ADDR_CAPT) begin
      nxt_prdata[WIDTH-1:0] = capture_value_reg_ff;
    end else if (i_paddr == `T16WG_ADDR_IRQ_STAT) begin
      nxt_prdata[2:0] = irq_stat_ff;
    end else if (i_paddr == `T16WG_ADDR_IRQ_CLR) begin
      nxt_prdata = 32'h0000_0000;
    end else if (i_paddr == `T16WG_ADDR_IRQ_EN) begin
      nxt_prdata[2:0] = irq_en_ff;
    end else if (i_paddr == `T16WG_ADDR_PIN_DIR) begin
      nxt_prdata[1:0] = pin_dir_ff;
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  // Answer after one wait cycle in the access phase
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= i_psel & i_penable & ~pready_ff;
      pslverr_ff <= i_psel & i_penable & ~pready_ff & nxt_pslverr;
      prdata_ff <= (i_psel & i_penable & ~pready_ff & ~i_pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      waveform_control_a_ff <= `T16WG_CTRL_A_RST;
      control_b_ff <= `T16WG_CTRL_B_RST;
      cmp_buf_a_ff <= `T16WG_WORD_RST;
      cmp_buf_b_ff <= `T16WG_WORD_RST;
      capture_value_reg_ff <= `T16WG_WORD_RST;
      irq_en_ff <= `T16WG_IRQ_RST;
      pin_dir_ff <= `T16WG_DIR_RST;
    end else if (wr) begin
      if (i_paddr == `T16WG_ADDR_CTRL_A) begin
        waveform_control_a_ff <= i_pwdata[7:0] & `T16WG_CTRL_A_MASK;
      end else if (i_paddr == `T16WG_ADDR_CTRL_B) begin
        control_b_ff <= i_pwdata[4:0];
      end else if (i_paddr == `T16WG_ADDR_CMP_A) begin
        cmp_buf_a_ff <= i_pwdata[WIDTH-1:0];
      end else if (i_paddr == `T16WG_ADDR_CMP_B) begin
        cmp_buf_b_ff <= i_pwdata[WIDTH-1:0];
      end else if (i_paddr == `T16WG_ADDR_CAPT) begin
        capture_value_reg_ff <= i_pwdata[WIDTH-1:0];
      end else if (i_paddr == `T16WG_ADDR_IRQ_EN) begin
        irq_en_ff <= i_pwdata[2:0];
      end else if (i_paddr == `T16WG_ADDR_PIN_DIR) begin
        pin_dir_ff <= i_pwdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Counter sequence
  // --------------------------------------------------------------------
  always @* begin
    nxt_count = counter_value_ff;
    nxt_up = count_up_ff;
    if (wr && (i_paddr == `T16WG_ADDR_COUNT)) begin
      nxt_count = i_pwdata[WIDTH-1:0];
    end else if (timer_tick_enable) begin
      if (is_dual) begin
        if (count_up_ff && at_top) begin
          nxt_up = 1'b0;
          nxt_count = counter_value_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (!count_up_ff && at_bottom) begin
          nxt_up = 1'b1;
          nxt_count = counter_value_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end else if (count_up_ff) begin
          nxt_count = counter_value_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
          nxt_count = counter_value_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end else begin
        nxt_up = 1'b1;
        if (at_top) begin
          nxt_count = `T16WG_BOTTOM;
        end else begin
          nxt_count = counter_value_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      counter_value_ff <= `T16WG_WORD_RST;
      count_up_ff <= 1'b1;
    end else begin
      counter_value_ff <= nxt_count;
      count_up_ff <= nxt_up;
    end
  end

  // --------------------------------------------------------------------
  // Compare channels
  // --------------------------------------------------------------------
  t16wg_compare #(.WIDTH(WIDTH)) u_chan_a (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(timer_tick_enable),
    .i_count(counter_value_ff),
    .i_top(top),
    .i_buffer(cmp_buf_a_ff),
    .i_immediate(immediate),
    .i_reload(reload),
    .i_fast(is_fast),
    .i_dual(is_dual),
    .i_count_up(count_up_ff),
    .i_at_top(at_top),
    .i_toggle_ok(tog_ok_a),
    .i_out_mode(waveform_control_a_ff[`T16WG_CA_MODE_A]),
    .o_active(act_a),
    .o_wave(wave_a),
    .o_connected(conn_a),
    .o_flag_set(flag_a)
  );

  // Channel B never toggles in a PWM mode
  t16wg_compare #(.WIDTH(WIDTH)) u_chan_b (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_tick(timer_tick_enable),
    .i_count(counter_value_ff),
    .i_top(top),
    .i_buffer(cmp_buf_b_ff),
    .i_immediate(immediate),
    .i_reload(reload),
    .i_fast(is_fast),
    .i_dual(is_dual),
    .i_count_up(count_up_ff),
    .i_at_top(at_top),
    .i_toggle_ok(~(is_fast | is_dual)),
    .i_out_mode(waveform_control_a_ff[`T16WG_CA_MODE_B]),
    .o_active(act_b),
    .o_wave(wave_b),
    .o_connected(conn_b),
    .o_flag_set(flag_b)
  );

  // --------------------------------------------------------------------
  // Interrupt status, clear and enable
  // --------------------------------------------------------------------
  assign irq_set = {flag_b, flag_a, ovf_set};
  assign irq_clr = (wr && (i_paddr == `T16WG_ADDR_IRQ_CLR)) ? i_pwdata[2:0] : `T16WG_IRQ_RST;

  // A set in the same cycle as its clear wins
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_ff <= `T16WG_IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  // --------------------------------------------------------------------
  // Output flops
  // --------------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_a_ff <= 1'b0;
      oe_a_ff <= 1'b0;
      pin_b_ff <= 1'b0;
      oe_b_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_a_ff <= conn_a & wave_a;
      oe_a_ff <= conn_a & pin_dir_ff[0];
      pin_b_ff <= conn_b & wave_b;
      oe_b_ff <= conn_b & pin_dir_ff[1];
      irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_set) & irq_en_ff);
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_chan_a_wave_pin = pin_a_ff;
  assign o_chan_a_wave_oe = oe_a_ff;
  assign o_chan_b_wave_pin = pin_b_ff;
  assign o_chan_b_wave_oe = oe_b_ff;
  assign o_irq = irq_ff;

endmodule

// File: tb/t16wg_timer_asserts.sv
// Checker for bus handshake, register read-back, pin ownership and interrupt gating
`timescale 1ns/1ns
`include "t16wg_defs.vh"
module t16wg_timer_asserts (
  input wire i_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [5:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_chan_a_wave_pin,
  input wire o_chan_a_wave_oe,
  input wire o_chan_b_wave_pin,
  input wire o_chan_b_wave_oe,
  input wire o_irq
);
  // ------------------------------
  // Shadow of written registers
  // ------------------------------
  logic [7:0] ctl_a_ff;
  logic [1:0] mode_hi_ff;
  logic [1:0] dir_ff;
  logic [2:0] en_ff;
  logic [3:0] mode;
  logic wr, pwm, conn_a, conn_b;
  assign wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
  assign mode = {mode_hi_ff, ctl_a_ff[1:0]};
  assign pwm = !(mode inside {4'h0, 4'h4, 4'hc});
  assign conn_a = ctl_a_ff[7:6] != 2'h0 && !(ctl_a_ff[7:6] == 2'h1 && pwm && !mode[3]);
  assign conn_b = ctl_a_ff[5:4] != 2'h0 && !(ctl_a_ff[5:4] == 2'h1 && pwm);
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_a_ff <= 8'h00;
      mode_hi_ff <= 2'h0;
      dir_ff <= 2'h0;
      en_ff <= 3'h0;
    end else if (wr) begin
      case (i_paddr)
        `T16WG_ADDR_CTRL_A: ctl_a_ff <= i_pwdata[7:0] & `T16WG_CTRL_A_MASK;
        `T16WG_ADDR_CTRL_B: mode_hi_ff <= i_pwdata[4:3];
        `T16WG_ADDR_IRQ_EN: en_ff <= i_pwdata[2:0];
        `T16WG_ADDR_PIN_DIR: dir_ff <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ------------------------------
  // Properties
  // ------------------------------
  property p_ready_lat;
    i_psel && !i_penable |=> !o_pready ##1 o_pready;
  endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("ready latency wrong");
  property p_ready_once;
    o_pready |=> !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
  property p_err_map;
    o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > `T16WG_ADDR_PIN_DIR);
  endproperty
  a_err_map: assert property (p_err_map) else $error("error response wrong");
  property p_idle_zero;
    !o_pready |-> o_prdata == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside transfer");
  property p_ctl_a_read;
    o_pready && !i_pwrite && i_paddr == `T16WG_ADDR_CTRL_A |-> o_prdata == {24'h0, ctl_a_ff};
  endproperty
  a_ctl_a_read: assert property (p_ctl_a_read) else $error("control A read-back wrong");
  property p_oe_a;
    o_chan_a_wave_oe == $past(conn_a && dir_ff[0]);
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("channel A drive enable wrong");
  property p_oe_b;
    o_chan_b_wave_oe == $past(conn_b && dir_ff[1]);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("channel B drive enable wrong");
  property p_pin_off;
    ($past(conn_a) || !o_chan_a_wave_pin) && ($past(conn_b) || !o_chan_b_wave_pin);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disconnected pin not low");
  property p_irq_gate;
    o_irq |-> $past(en_ff) != 3'h0;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt with none enabled");
endmodule
bind t16wg_timer t16wg_timer_asserts u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_chan_a_wave_pin(o_chan_a_wave_pin), .o_chan_a_wave_oe(o_chan_a_wave_oe),
  .o_chan_b_wave_pin(o_chan_b_wave_pin), .o_chan_b_wave_oe(o_chan_b_wave_oe), .o_irq(o_irq));

// File: tb/tb_top.sv
// Self-checking bench for the waveform timer: registers, interrupt and pin waveforms
`timescale 1ns/1ns
`include "t16wg_defs.vh"
module tb_top;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [5:0] i_paddr = 6'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] rd;
  logic er;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_chan_a_wave_pin, o_chan_a_wave_oe;
  wire o_chan_b_wave_pin, o_chan_b_wave_oe, o_irq;
  int mismatches = 0;
  int checks = 0;
  always #4 i_clk = ~i_clk;
  t16wg_timer u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_chan_a_wave_pin(o_chan_a_wave_pin), .o_chan_a_wave_oe(o_chan_a_wave_oe),
    .o_chan_b_wave_pin(o_chan_b_wave_pin), .o_chan_b_wave_oe(o_chan_b_wave_oe), .o_irq(o_irq));
  // ------------------------------
  // Tasks and expectations
  // ------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out();
    end else begin
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask
  function automatic int fast_hi(input int c);
    return (c + 1) * 10;
  endfunction
  function automatic int dual_hi(input int c);
    return c * 20;
  endfunction
  // Channel B never toggles in a PWM mode, otherwise it follows channel A
  function automatic int b_exp(input logic [3:0] m, input logic [1:0] com, input int e);
    return (com == 2'h1 && !(m inside {4'h0, 4'h4, 4'hc})) ? 0 : e;
  endfunction
  // Stop, configure, restart, let it settle, then count high cycles of pins A and B
  task automatic run(input logic [3:0] m, input logic [2:0] cs, input logic [1:0] com,
      input logic [15:0] top, input logic [15:0] ca, input int win, input int exp);
    int hi;
    int hb;
    hi = 0;
    hb = 0;
    chk(m == 4'hd, 1'b0);
    apb(1, `T16WG_ADDR_CTRL_B, {27'h0, m[3:2], 3'h0});
    apb(1, `T16WG_ADDR_CTRL_A, {24'h0, com, com, 2'h0, m[1:0]});
    apb(1, `T16WG_ADDR_CAPT, {16'h0, top});
    apb(1, `T16WG_ADDR_CMP_A, {16'h0, ca});
    apb(1, `T16WG_ADDR_CMP_B, {16'h0, ca});
    apb(1, `T16WG_ADDR_COUNT, 32'h0);
    apb(1, `T16WG_ADDR_CTRL_B, {27'h0, m[3:2], cs});
    repeat (win + 2100) @(posedge i_clk);
    repeat (win) begin
      @(posedge i_clk);
      hi += (o_chan_a_wave_pin === 1'b1);
      hb += (o_chan_b_wave_pin === 1'b1);
    end
    chk(hi, exp);
    chk(hb, b_exp(m, com, exp));
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    int c;
    void'($urandom(32'h00e2a3bf));
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(0, `T16WG_ADDR_CTRL_A, 32'h0);
    chk(rd, 32'h0);
    apb(1, `T16WG_ADDR_CTRL_A, 32'hff);
    apb(0, `T16WG_ADDR_CTRL_A, 32'h0);
    chk(rd, 32'hf3);
    apb(0, 6'h28, 32'h0);
    chk(er, 1'b1);
    apb(1, `T16WG_ADDR_PIN_DIR, 32'h3);
    for (int k = 0; k < 4; k++) begin
      run(4'h4, 3'h1, k[1:0], 16'h0, 16'h3, 40, (k == 1) ? 20 : (k == 3) ? 40 : 0);
    end
    run(4'h4, 3'h2, 2'h1, 16'h0, 16'h3, 320, 160);
    run(4'h5, 3'h1, 2'h1, 16'h0, 16'h3, 100, 0);
    run(4'h5, 3'h1, 2'h2, 16'h0, 16'h7f, 512, 256);
    run(4'he, 3'h1, 2'h1, 16'h9, 16'h3, 100, 50);
    run(4'hf, 3'h1, 2'h1, 16'h0, 16'h9, 100, 50);
    run(4'he, 3'h1, 2'h2, 16'h9, 16'h9, 100, 100);
    for (int k = 0; k < 3; k++) begin
      c = $urandom_range(8, 0);
      run(4'he, 3'h1, 2'h2, 16'h9, c[15:0], 100, fast_hi(c));
      run(4'he, 3'h1, 2'h3, 16'h9, c[15:0], 100, 100 - fast_hi(c));
      c = $urandom_range(8, 1);
      run(4'ha, 3'h1, 2'h2, 16'h9, c[15:0], 180, dual_hi(c));
      run(4'h8, 3'h1, 2'h3, 16'h9, c[15:0], 180, 180 - dual_hi(c));
    end
    run(4'hb, 3'h1, 2'h1, 16'h0, 16'h9, 180, 90);
    run(4'h1, 3'h1, 2'h1, 16'h0, 16'h3, 100, 0);
    run(4'h3, 3'h1, 2'h2, 16'h0, 16'h1ff, 2046, 1022);
    run(4'h4, 3'h1, 2'h1, 16'h0, 16'h3, 40, 20);
    apb(1, `T16WG_ADDR_IRQ_CLR, 32'h7);
    repeat (10) @(posedge i_clk);
    apb(0, `T16WG_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h6);
    chk(o_irq, 1'b0);
    apb(1, `T16WG_ADDR_IRQ_EN, 32'h2);
    repeat (3) @(posedge i_clk);
    chk(o_irq, 1'b1);
    apb(1, `T16WG_ADDR_IRQ_EN, 32'h1);
    repeat (3) @(posedge i_clk);
    chk(o_irq, 1'b0);
    apb(1, `T16WG_ADDR_CTRL_B, 32'h1);
    apb(1, `T16WG_ADDR_COUNT, 32'hfff0);
    repeat (30) @(posedge i_clk);
    chk(o_irq, 1'b1);
    apb(1, `T16WG_ADDR_CTRL_B, 32'h0);
    apb(1, `T16WG_ADDR_IRQ_CLR, 32'h7);
    repeat (3) @(posedge i_clk);
    chk(o_irq, 1'b0);
    apb(1, `T16WG_ADDR_IRQ_STAT, 32'h7);
    apb(0, `T16WG_ADDR_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    apb(0, `T16WG_ADDR_IRQ_CLR, 32'h0);
    chk(rd, 32'h0);
    // Reset in mid-run must clear a nonzero control A
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(0, `T16WG_ADDR_CTRL_A, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
